// file: core/phy_event_status_and_config.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`include "phy_event_cfg.svh"
`default_nettype none

module phy_event_status_and_config (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire phy_event_pkg::addr_t s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire phy_event_pkg::addr_t s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Event sources: event_pulse_i carries one-cycle pulses at status register bit positions; the next three inputs are live levels
  input wire phy_event_pkg::reg16_t event_pulse_i,
  input wire logic energy_efficient_error_i,
  input wire logic wake_packet_seen_i,
  input wire logic mac_buffer_overrun_i,
  input wire logic powered_device_probe_set_i,
  // Interrupt pin, polarity programmable
  output logic interrupt_pin_o,
  // Configuration outputs
  output logic powered_device_probe_enable_o,
  output logic serial_tx_error_suppress_o,
  output logic serial_soft_reset_o,
  output logic [3:0] downshift_attempt_count_o,
  output logic downshift_enable_o,
  output logic downshift_enhanced_enable_o,
  output logic serial_link_negotiation_enable_o,
  output logic downshift_to_ten_enable_o,
  output phy_event_pkg::tx_clk_sel_e tx_clock_select_o,
  output logic tx_clock_enable_o,
  output logic collision_in_full_duplex_enable_o,
  output logic old_scrambler_autoselect_o,
  output logic master_semi_cross_enable_o,
  output logic slave_semi_cross_enable_o
);
  import phy_event_pkg::*;

  localparam addr_t MASK_ADDR = addr_t'({`EVENT_MASK_IDX, 2'b00});
  localparam addr_t STATUS_ADDR = addr_t'({`EVENT_STATUS_IDX, 2'b00});
  localparam addr_t CONFIG_ADDR = addr_t'({`GEN_CONFIG_IDX, 2'b00});

  // Bus state
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  addr_t awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // Register state
  reg16_t mask_q, mask_d;
  reg16_t status_q, status_d;
  reg16_t config_q, config_d;
  logic soft_pulse_q, soft_pulse_d;
  logic int_pin_q, int_pin_d;

  logic aw_fire, w_fire, ar_fire, do_write, status_read;
  addr_t wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  reg16_t wr_bytes;
  reg16_t status_view;
  logic pending;

  assign s_axi_awready_o = !aw_have_q && !bvalid_q;
  assign s_axi_wready_o = !w_have_q && !bvalid_q;
  assign s_axi_arready_o = !rvalid_q;
  assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign do_write = (aw_have_q || aw_fire) && (w_have_q || w_fire);
  assign wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr_i;
  assign wr_data = w_have_q ? wdata_q : s_axi_wdata_i;
  assign wr_strb = w_have_q ? wstrb_q : s_axi_wstrb_i;
  assign status_read = ar_fire && (s_axi_araddr_i == STATUS_ADDR);

  // Level indications are read live so they never go stale between reads
  always_comb begin
    status_view = status_q;
    status_view[`ST_EEE_ERR_BIT] = energy_efficient_error_i;
    status_view[`ST_WAKE_BIT] = wake_packet_seen_i;
    status_view[`ST_MAC_BUF_BIT] = mac_buffer_overrun_i;
  end

  assign pending = |(status_view & mask_q);

  // Write and read channel handling
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (aw_fire) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr_i;
    end
    if (w_fire) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata_i;
      wstrb_d = s_axi_wstrb_i;
    end
    if (bvalid_q && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      // Status is readable but writes to it are silently accepted
      bresp_d = (wr_addr == MASK_ADDR || wr_addr == STATUS_ADDR || wr_addr == CONFIG_ADDR)
        ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      unique case (s_axi_araddr_i)
        MASK_ADDR: rdata_d = {16'h0000, mask_q};
        STATUS_ADDR: rdata_d = {16'h0000, status_view};
        CONFIG_ADDR: rdata_d = {16'h0000, config_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
  end

  // Register file: byte lanes 0 and 1 carry the 16-bit registers
  always_comb begin
    wr_bytes = {(wr_strb[1] ? wr_data[15:8] : 8'h00), (wr_strb[0] ? wr_data[7:0] : 8'h00)};
    mask_d = mask_q;
    config_d = config_q;
    soft_pulse_d = 1'b0;
    // Latch new events; a read clears only what it returned, the set wins
    status_d = status_q & ~(status_read ? `STATUS_LATCH_MASK : 16'h0000);
    status_d = status_d | (event_pulse_i & `STATUS_LATCH_MASK);
    if (do_write && wr_addr == MASK_ADDR) begin
      if (wr_strb[0]) mask_d[7:0] = wr_bytes[7:0];
      if (wr_strb[1]) mask_d[15:8] = wr_bytes[15:8];
    end
    if (do_write && wr_addr == CONFIG_ADDR) begin
      if (wr_strb[0]) config_d[7:0] = wr_bytes[7:0];
      if (wr_strb[1]) config_d[15:8] = wr_bytes[15:8];
      soft_pulse_d = wr_strb[1] && wr_bytes[`CFG_SOFT_RESET_BIT];
    end
    config_d[`CFG_SOFT_RESET_BIT] = 1'b0;
    if (powered_device_probe_set_i) begin
      config_d[`CFG_PD_PROBE_BIT] = 1'b1;
    end
    // Polarity applies to the pin, so a change never spikes the raw level
    int_pin_d = config_q[`CFG_INT_POLARITY_BIT] ? !pending : pending;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
      mask_q <= `EVENT_MASK_RESET;
      status_q <= `EVENT_STATUS_RESET;
      config_q <= `GEN_CONFIG_RESET;
      soft_pulse_q <= 1'b0;
      int_pin_q <= 1'b1;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      mask_q <= mask_d;
      status_q <= status_d;
      config_q <= config_d;
      soft_pulse_q <= soft_pulse_d;
      int_pin_q <= int_pin_d;
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign interrupt_pin_o = int_pin_q;

  assign powered_device_probe_enable_o = config_q[`CFG_PD_PROBE_BIT];
  assign serial_tx_error_suppress_o = config_q[`CFG_TX_ERR_SUPPRESS_BIT];
  assign serial_soft_reset_o = soft_pulse_q;
  assign downshift_attempt_count_o =
    4'(4'h1 << config_q[`CFG_ATTEMPT_HI:`CFG_ATTEMPT_LO]);
  assign downshift_enable_o = config_q[`CFG_DOWNSHIFT_EN_BIT];
  assign downshift_enhanced_enable_o = config_q[`CFG_ENHANCED_BIT];
  assign serial_link_negotiation_enable_o = config_q[`CFG_SERIAL_NEG_BIT];
  assign downshift_to_ten_enable_o = config_q[`CFG_TEN_FALLBACK_BIT];
  assign tx_clock_select_o = tx_clk_sel_e'(config_q[`CFG_TXCLK_HI:`CFG_TXCLK_LO]);
  assign tx_clock_enable_o = !config_q[`CFG_TXCLK_HI];
  assign collision_in_full_duplex_enable_o = config_q[`CFG_COL_FD_BIT];
  assign old_scrambler_autoselect_o = config_q[`CFG_OLD_SCRAMBLER_BIT];
  assign master_semi_cross_enable_o = config_q[`CFG_MASTER_SEMI_BIT];
  assign slave_semi_cross_enable_o = config_q[`CFG_SLAVE_SEMI_BIT];

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence soft_write_s;
    do_write && wr_addr == CONFIG_ADDR && wr_strb[1] && wr_data[`CFG_SOFT_RESET_BIT];
  endsequence

  sequence one_pulse_s;
    serial_soft_reset_o ##1 !serial_soft_reset_o;
  endsequence

  event_latch_a: assert property (
    event_pulse_i[15] |=> status_q[15])
    else $error("event did not latch");

  read_clear_a: assert property (
    status_read && !event_pulse_i[15] |=> !status_q[15] && s_axi_rdata_o[15] == $past(status_q[15]))
    else $error("status read did not return and clear bit");

  set_wins_a: assert property (
    status_read && event_pulse_i[10] |=> status_q[10])
    else $error("event lost on read clear");

  level_keep_a: assert property (
    status_read |=> s_axi_rdata_o[`ST_WAKE_BIT] == $past(wake_packet_seen_i))
    else $error("level bit not mirrored");

  soft_pulse_a: assert property (
    soft_write_s |=> one_pulse_s ##0 !config_q[`CFG_SOFT_RESET_BIT])
    else $error("soft reset pulse wrong");

  irq_polarity_a: assert property (
    ##1 interrupt_pin_o == ($past(pending) ^ $past(config_q[`CFG_INT_POLARITY_BIT])))
    else $error("interrupt pin level wrong");

  irq_gate_a: assert property (
    (status_view & mask_q) == 16'h0000 ##1 (status_view & mask_q) == 16'h0000
      |-> interrupt_pin_o == $past(config_q[`CFG_INT_POLARITY_BIT]))
    else $error("interrupt asserted without enabled event");

  attempt_map_a: assert property (
    downshift_attempt_count_o == (4'h1 << config_q[11:10]) && $onehot(downshift_attempt_count_o))
    else $error("attempt count decode wrong");

  probe_set_a: assert property (
    powered_device_probe_set_i |=> powered_device_probe_enable_o)
    else $error("probe enable not set by hardware");

  txclk_off_a: assert property (
    tx_clock_enable_o == (tx_clock_select_o inside {TXCLK_2M5, TXCLK_25M}))
    else $error("tx clock enable wrong");

  latch_keep_a: assert property (
    !status_read |=> ($past(status_q) & ~status_q & `STATUS_LATCH_MASK) == 16'h0000)
    else $error("latched bit dropped without a read");

  event_set_a: assert property (
    |(event_pulse_i & `STATUS_LATCH_MASK)
      |=> (status_q & $past(event_pulse_i)) == ($past(event_pulse_i) & `STATUS_LATCH_MASK))
    else $error("event bit not latched");

  read_clear_all_a: assert property (
    status_read |=> (status_q & `STATUS_LATCH_MASK & ~$past(event_pulse_i)) == 16'h0000)
    else $error("status read left a stale latched bit");

  level_mirror_a: assert property (
    status_read |=> s_axi_rdata_o[`ST_EEE_ERR_BIT] == $past(energy_efficient_error_i)
      && s_axi_rdata_o[`ST_MAC_BUF_BIT] == $past(mac_buffer_overrun_i))
    else $error("level bits not mirrored");

  carrier_event_a: assert property (
    event_pulse_i[8] |=> status_q[8])
    else $error("spurious carrier event not latched");

  fifo_event_a: assert property (
    event_pulse_i[7] |=> status_q[7])
    else $error("sample fifo event not latched");

  cross_event_a: assert property (
    event_pulse_i[6] |=> status_q[6])
    else $error("crossover event not latched");

  sleep_event_a: assert property (
    event_pulse_i[4] |=> status_q[4])
    else $error("sleep event not latched");

  polarity_event_a: assert property (
    event_pulse_i[1] |=> status_q[1])
    else $error("polarity event not latched");

  downshift_event_a: assert property (
    event_pulse_i[5] |=> status_q[5])
    else $error("downshift event not latched");

  bresp_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before accept");

  rdata_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before accept");

  tx_err_write_a: assert property (
    do_write && wr_addr == CONFIG_ADDR && wr_strb[1]
      |=> serial_tx_error_suppress_o == $past(wr_data[`CFG_TX_ERR_SUPPRESS_BIT]))
    else $error("transmit error suppress not written");

  pulse_cause_a: assert property (
    !(do_write && wr_addr == CONFIG_ADDR && wr_strb[1] && wr_data[`CFG_SOFT_RESET_BIT])
      |=> !serial_soft_reset_o)
    else $error("soft reset pulse without a write");

  config_stable_a: assert property (
    !do_write && !powered_device_probe_set_i |=> $stable(config_q))
    else $error("configuration changed without a write");

  mask_gate_a: assert property (
    |(status_view & mask_q) |=> interrupt_pin_o != $past(config_q[`CFG_INT_POLARITY_BIT]))
    else $error("interrupt not asserted for enabled event");
endmodule
`default_nettype wire

// file: pkg/phy_event_cfg.svh
`ifndef PHY_EVENT_CFG_SVH
`define PHY_EVENT_CFG_SVH

// Register indices; the AXI byte address is four times the index
`define ADDR_W 8
`define EVENT_MASK_IDX 8'h12
`define EVENT_STATUS_IDX 8'h13
`define GEN_CONFIG_IDX 8'h14

// Reset values
`define EVENT_MASK_RESET 16'h0000
`define EVENT_STATUS_RESET 16'h0000
`define GEN_CONFIG_RESET 16'h29c7

// Status fields that latch high and clear when read
`define STATUS_LATCH_MASK 16'hfdf3
// Status fields that only mirror a level
`define STATUS_LEVEL_MASK 16'h020c
`define ST_EEE_ERR_BIT 9
`define ST_WAKE_BIT 3
`define ST_MAC_BUF_BIT 2

// Configuration field positions
`define CFG_PD_PROBE_BIT 15
`define CFG_TX_ERR_SUPPRESS_BIT 14
`define CFG_INT_POLARITY_BIT 13
`define CFG_SOFT_RESET_BIT 12
`define CFG_ATTEMPT_HI 11
`define CFG_ATTEMPT_LO 10
`define CFG_DOWNSHIFT_EN_BIT 9
`define CFG_ENHANCED_BIT 8
`define CFG_SERIAL_NEG_BIT 7
`define CFG_TEN_FALLBACK_BIT 6
`define CFG_TXCLK_HI 5
`define CFG_TXCLK_LO 4
`define CFG_COL_FD_BIT 3
`define CFG_OLD_SCRAMBLER_BIT 2
`define CFG_MASTER_SEMI_BIT 1
`define CFG_SLAVE_SEMI_BIT 0

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: pkg/phy_event_pkg.sv
`default_nettype none
package phy_event_pkg;
  typedef logic [15:0] reg16_t;
  typedef logic [7:0] addr_t;
  typedef enum logic [1:0] {
    TXCLK_2M5,
    TXCLK_25M,
    TXCLK_OFF_A,
    TXCLK_OFF_B
  } tx_clk_sel_e;
endpackage
`default_nettype wire

// file: tb/phy_event_status_and_config_tb.sv
`include "phy_event_cfg.svh"
`default_nettype none
module phy_event_status_and_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_event_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  addr_t awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  reg16_t pulse = 16'h0000;
  logic eee = 1'b0, wake = 1'b0, macb = 1'b0, pd_set = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, pd_en, sup, sreset, tx_en;
  logic col, old, ms, ss, ds_en, enh, neg, ten;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] att;
  tx_clk_sel_e tx_sel;
  int err_count = 0;
  int checked = 0;
  int sr_cnt = 0;
  logic [1:0] rs;
  logic [31:0] rv;

  always #12.5 clk_sys_i = ~clk_sys_i;
  // Counts cycles in which the soft reset pulse stands
  always @(posedge clk_sys_i) if (sreset === 1'b1) sr_cnt <= sr_cnt + 1;

  phy_event_status_and_config DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .event_pulse_i(pulse), .energy_efficient_error_i(eee),
    .wake_packet_seen_i(wake), .mac_buffer_overrun_i(macb),
    .powered_device_probe_set_i(pd_set), .interrupt_pin_o(irq),
    .powered_device_probe_enable_o(pd_en), .serial_tx_error_suppress_o(sup),
    .serial_soft_reset_o(sreset), .downshift_attempt_count_o(att),
    .downshift_enable_o(ds_en), .downshift_enhanced_enable_o(enh),
    .serial_link_negotiation_enable_o(neg), .downshift_to_ten_enable_o(ten),
    .tx_clock_select_o(tx_sel), .tx_clock_enable_o(tx_en),
    .collision_in_full_duplex_enable_o(col), .old_scrambler_autoselect_o(old),
    .master_semi_cross_enable_o(ms), .slave_semi_cross_enable_o(ss)
  );

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ready is sampled at the falling edge: it only moves at rising edges
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] s);
    logic pa, pw, a, w, got;
    pa = 1'b1;
    pw = 1'b1;
    got = 1'b0;
    awaddr <= {idx[5:0], 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk_sys_i);
      a = pa && (awready === 1'b1);
      w = pw && (wready === 1'b1);
      @(posedge clk_sys_i);
      if (a) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (w) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    while (!got) begin
      @(negedge clk_sys_i);
      got = (bvalid === 1'b1);
      rs = bresp;
      @(posedge clk_sys_i);
    end
    bready <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] idx);
    logic got;
    got = 1'b0;
    araddr <= {idx[5:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(negedge clk_sys_i);
      got = (arready === 1'b1);
      @(posedge clk_sys_i);
    end
    arvalid <= 1'b0;
    got = 1'b0;
    while (!got) begin
      @(negedge clk_sys_i);
      got = (rvalid === 1'b1);
      rv = rdata;
      rs = rresp;
      @(posedge clk_sys_i);
    end
    rready <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic pulse_ev(input reg16_t v);
    pulse <= v;
    @(posedge clk_sys_i);
    pulse <= 16'h0000;
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic chk_cfg(input logic [15:0] c);
    chk("cfg_outputs", {20'h0_0000, c[15:14], c[9:3], c[2:0]},
        {20'h0_0000, pd_en, sup, ds_en, enh, neg, ten, tx_sel, col, old, ms, ss});
    chk("attempt_count", 32'(4'h1 << c[11:10]), {28'h000_0000, att});
    chk("tx_clock_enable", {31'h0, ~c[5]}, {31'h0, tx_en});
  endtask

  task t_reset;
    rd(`EVENT_STATUS_IDX);
    chk("status_reset", 32'h0000_0000, rv);
    rd(`GEN_CONFIG_IDX);
    chk("config_reset", 32'h0000_29c7, rv);
    chk("config_rresp", {30'h0, `RESP_OKAY}, {30'h0, rs});
    chk_cfg(16'h29c7);
    chk("pin_idle", 32'h1, {31'h0, irq});
  endtask

  task t_latch;
    pulse_ev(16'hffff);
    rd(`EVENT_STATUS_IDX);
    chk("latched", 32'h0000_fdf3, rv);
    chk("pin_masked", 32'h1, {31'h0, irq});
    rd(`EVENT_STATUS_IDX);
    chk("cleared", 32'h0000_0000, rv);
  endtask

  task t_level;
    eee <= 1'b1;
    wake <= 1'b1;
    macb <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rd(`EVENT_STATUS_IDX);
    rd(`EVENT_STATUS_IDX);
    chk("levels_kept", 32'h0000_020c, rv);
    eee <= 1'b0;
    wake <= 1'b0;
    macb <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rd(`EVENT_STATUS_IDX);
    chk("levels_low", 32'h0000_0000, rv);
  endtask

  task t_cfg;
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 16'((i << 10) | (i << 4) | ((i % 2 == 1) ? 32'hc3c8 : 32'h2237));
      wr(`GEN_CONFIG_IDX, v, 4'h3);
      rd(`GEN_CONFIG_IDX);
      chk("config_rw", {16'h0000, v}, rv);
      chk_cfg(v);
      chk("pin_polarity", {31'h0, v[13]}, {31'h0, irq});
    end
  endtask

  task t_soft;
    int sr_base;
    wr(`GEN_CONFIG_IDX, 16'h0000, 4'h3);
    sr_base = sr_cnt;
    wr(`GEN_CONFIG_IDX, 16'h39c7, 4'h3);
    repeat (3) @(posedge clk_sys_i);
    chk("soft_pulse_cycles", 32'd1, 32'(sr_cnt - sr_base));
    rd(`GEN_CONFIG_IDX);
    chk("soft_self_clear", 32'h0000_29c7, rv);
    pd_set <= 1'b1;
    @(posedge clk_sys_i);
    pd_set <= 1'b0;
    rd(`GEN_CONFIG_IDX);
    chk("probe_hw_set", 32'h0000_a9c7, rv);
  endtask

  task t_irq;
    wr(`GEN_CONFIG_IDX, 16'h29c7, 4'h3);
    wr(`EVENT_MASK_IDX, 16'h0001, 4'h3);
    pulse_ev(16'h8000);
    chk("pin_other_bit", 32'h1, {31'h0, irq});
    pulse_ev(16'h0001);
    chk("pin_active_low", 32'h0, {31'h0, irq});
    wr(`GEN_CONFIG_IDX, 16'h09c7, 4'h3);
    repeat (2) @(posedge clk_sys_i);
    chk("pin_active_high", 32'h1, {31'h0, irq});
    rd(`EVENT_STATUS_IDX);
    chk("both_latched", 32'h0000_8001, rv);
    repeat (2) @(posedge clk_sys_i);
    chk("pin_released", 32'h0, {31'h0, irq});
  endtask

  // Reset in mid-run must bring back defaults that differ from what t_irq left
  task t_rst;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk("pin_after_reset", 32'h1, {31'h0, irq});
    rd(`GEN_CONFIG_IDX);
    chk("config_after_reset", 32'h0000_29c7, rv);
    rd(`EVENT_MASK_IDX);
    chk("mask_after_reset", 32'h0000_0000, rv);
  endtask

  task t_bad;
    rd(8'h15);
    chk("unmapped_rresp", {30'h0, `RESP_SLVERR}, {30'h0, rs});
    chk("unmapped_rdata", 32'h0000_0000, rv);
    wr(8'h15, 16'hffff, 4'hf);
    chk("unmapped_bresp", {30'h0, `RESP_SLVERR}, {30'h0, rs});
    pulse_ev(16'h0400);
    wr(`EVENT_STATUS_IDX, 16'h0000, 4'h3);
    chk("status_wr_bresp", {30'h0, `RESP_OKAY}, {30'h0, rs});
    rd(`EVENT_STATUS_IDX);
    chk("status_wr_ignored", 32'h0000_0400, rv);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_latch();
    t_level();
    t_cfg();
    t_soft();
    t_irq();
    t_rst();
    t_bad();
    test_done();
  end

  initial begin
    #(25 * 5000);
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
